/* File: core/stc_defines.svh */
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH
// register byte offsets
`define STC_A_CTRL      8'h00
`define STC_A_LINE      8'h04
`define STC_A_COLS      8'h08
`define STC_A_ROWS      8'h0c
`define STC_A_FPER      8'h10
`define STC_A_EXPO      8'h14
`define STC_A_DELAY     8'h18
`define STC_A_FCNT      8'h1c
`define STC_A_STAT      8'h20
`define STC_A_FNUM      8'h24
`define STC_A_TSTAMP    8'h28
`define STC_A_USEC      8'h2c
// fields
`define STC_F_MODE      1:0
`define STC_F_ROLL      2
`define STC_F_EN        4:3
`define STC_F_POL       6:5
`define STC_F_SOFT      7
`define STC_F_CTRL      7:0
`define STC_F_COL_S     10:0
`define STC_F_COL_E     26:16
`define STC_F_HALF      15:0
// reset values
`define STC_RST_CTRL    8'h00
`define STC_RST_LINE    16'h0000
`define STC_RST_COL_S   11'h000
`define STC_RST_COL_E   11'h4ff
`define STC_RST_ROWS    16'h0400
`define STC_RST_FPER    32'h0000_0000
`define STC_RST_EXPO    32'h0000_0085
`define STC_RST_DELAY   32'h0000_0000
`define STC_RST_FCNT    16'h0001
// sensor and timing
`define STC_GRAN_SNAP   11'h00a
`define STC_GRAN_ROLL   11'h010
`define STC_LINE_GAP    16'h0002
`define STC_CLK_NS      10
`define STC_TICK_NS     15
`define STC_USEC_NS     1000
`define STC_STATUS_BITS 7'h41
`endif

/* File: core/stc_pkg.sv */
`include "stc_defines.svh"
package stc_pkg;
  typedef enum logic [1:0] {
    STC_FREE   = 2'h0,
    STC_MULTI  = 2'h1,
    STC_SINGLE = 2'h2,
    STC_EXT    = 2'h3
  } stc_mode_t;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DELAY  = 6'h02,
    ST_EXPOSE = 6'h04,
    ST_LEAD   = 6'h08,
    ST_READ   = 6'h10,
    ST_GAP    = 6'h20
  } stc_state_t;
  function automatic logic [10:0] stc_gran(input logic roll);
    return roll ? `STC_GRAN_ROLL : `STC_GRAN_SNAP;
  endfunction
endpackage

/* File: core/stc_status_if.sv */
`timescale 1ns/1ns
interface stc_status_if;
  logic        load;
  logic        trig;
  logic [31:0] fnum;
  logic [31:0] tstamp;
  logic        busy;
  logic        sbit;
  modport ctl (output load, trig, fnum, tstamp, input busy, sbit);
  modport ser (input load, trig, fnum, tstamp, output busy, sbit);
endinterface

/* File: core/stc_status_ser.sv */
`timescale 1ns/1ns
`include "stc_defines.svh"
module stc_status_ser
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // status word
  stc_status_if.ser st
);
  logic [64:0] sh;
  logic [6:0]  cnt;

  assign st.sbit = sh[64];
  assign st.busy = cnt != 7'h00;

  // flag, frame number, timestamp; both words msb first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh  <= 65'h0;
      cnt <= 7'h00;
    end else if (st.load) begin
      sh  <= {st.trig, st.fnum, st.tstamp};
      cnt <= `STC_STATUS_BITS;
    end else if (cnt != 7'h00) begin
      sh  <= {sh[63:0], 1'b0};
      cnt <= cnt - 7'h01;
    end
  end

  a_status_first: assert property (@(posedge hclk)
    disable iff (!hresetn) st.load |=> st.busy && st.sbit == $past(st.trig))
    else $error("first status bit is not the trigger flag");
  a_status_fnum: assert property (@(posedge hclk)
    disable iff (!hresetn) st.load |-> ##2 st.sbit == $past(st.fnum[31], 2))
    else $error("frame number not sent msb first");
  a_status_end: assert property (@(posedge hclk)
    disable iff (!hresetn) (cnt == 7'h01 && !st.load) |=> !st.busy)
    else $error("status word does not end after last bit");
endmodule // stc_status_ser

/* File: core/stc_tick_gen.sv */
`timescale 1ns/1ns
// fractional divider: NUM/DEN ticks per clock on average
module stc_tick_gen #(
  parameter int NUM = 10,
  parameter int DEN = 15
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // enable pulse
  output logic      tick
);
  logic [15:0] acc;
  logic [15:0] next_acc;

  assign next_acc = acc + 16'(NUM);
  assign tick     = next_acc >= 16'(DEN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= 16'h0000;
    end else if (tick) begin
      acc <= next_acc - 16'(DEN);
    end else begin
      acc <= next_acc;
    end
  end
endmodule // stc_tick_gen

/* File: core/stc_timing.sv */
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "stc_defines.svh"
module stc_timing
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // trigger pins
  input  wire logic [1:0]  trig_pin,
  // frame wires and trigger outputs
  output logic             line_valid_wire,
  output logic             frame_valid_wire,
  output logic             expose_out,
  output logic             delay_out
);
  stc_status_if st ();

  logic [7:0]  ctrl;
  logic [15:0] line_per;
  logic [10:0] col_s;
  logic [10:0] col_e;
  logic [15:0] rows;
  logic [31:0] frame_per;
  logic [31:0] expo;
  logic [31:0] delay;
  logic [15:0] fcount;
  stc_mode_t   mode;
  logic        roll;

  stc_state_t  state;
  stc_state_t  next_state;
  logic        tick15;
  logic        tick_us;
  logic [31:0] usec;
  logic [31:0] fp_cnt;
  logic [31:0] exp_cnt;
  logic [31:0] dly_cnt;
  logic        dly_run;
  logic [15:0] frames_left;
  logic        pend;
  logic        trig_seen;
  logic [31:0] fnum;
  logic [31:0] ts_cap;
  logic [15:0] lcnt;
  logic [15:0] row;
  logic        fv;

  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [1:0]  act;
  logic [1:0]  pin_en;
  logic [1:0]  pin_pol;
  logic        trig_lvl;
  logic        trig_prev;
  logic        trig_edge;
  logic        edge_mode;
  logic        acc_edge;
  logic        pend_set;
  logic        restart;
  logic        frame_go;
  logic [10:0] cols;
  logic [15:0] line_min;
  logic [15:0] line_eff;
  logic        line_end;
  logic        last_row;
  logic        dly_done;
  logic        exp_done;
  logic        gap_done;
  logic        rd_req;
  logic        wr_ph;
  logic [7:0]  wa;

  assign mode = stc_mode_t'(ctrl[`STC_F_MODE]);
  assign roll = ctrl[`STC_F_ROLL];

  // ahb-lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_req    = hsel && hready && htrans[1] && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wa    <= 8'h00;
    end else if (hready) begin
      wr_ph <= hsel && htrans[1] && hwrite;
      wa    <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= `STC_RST_CTRL;
      line_per  <= `STC_RST_LINE;
      col_s     <= `STC_RST_COL_S;
      col_e     <= `STC_RST_COL_E;
      rows      <= `STC_RST_ROWS;
      frame_per <= `STC_RST_FPER;
      expo      <= `STC_RST_EXPO;
      delay     <= `STC_RST_DELAY;
      fcount    <= `STC_RST_FCNT;
    end else if (wr_ph) begin
      case (wa)
        `STC_A_CTRL:  ctrl      <= hwdata[`STC_F_CTRL];
        `STC_A_LINE:  line_per  <= hwdata[`STC_F_HALF];
        `STC_A_COLS: begin
          col_s <= hwdata[`STC_F_COL_S];
          col_e <= hwdata[`STC_F_COL_E];
        end
        `STC_A_ROWS:  rows      <= hwdata[`STC_F_HALF];
        `STC_A_FPER:  frame_per <= hwdata;
        `STC_A_EXPO:  expo      <= hwdata;
        `STC_A_DELAY: delay     <= hwdata;
        `STC_A_FCNT:  fcount    <= hwdata[`STC_F_HALF];
        default: ;
      endcase
    end
  end

  // read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      case (haddr[7:0])
        `STC_A_CTRL:   hrdata <= {24'h0, ctrl};
        `STC_A_LINE:   hrdata <= {16'h0, line_per};
        `STC_A_COLS:   hrdata <= {5'h0, col_e, 5'h0, col_s};
        `STC_A_ROWS:   hrdata <= {16'h0, rows};
        `STC_A_FPER:   hrdata <= frame_per;
        `STC_A_EXPO:   hrdata <= expo;
        `STC_A_DELAY:  hrdata <= delay;
        `STC_A_FCNT:   hrdata <= {16'h0, fcount};
        `STC_A_STAT:   hrdata <= {frames_left, 5'h0, fv,
                                  trig_seen, pend, 2'h0, state};
        `STC_A_FNUM:   hrdata <= fnum;
        `STC_A_TSTAMP: hrdata <= ts_cap;
        `STC_A_USEC:   hrdata <= usec;
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // trigger sources: two-flop sync, then enable and polarity
  assign pin_en  = ctrl[`STC_F_EN];
  assign pin_pol = ctrl[`STC_F_POL];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_trig
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= trig_pin[gi];
          sync2[gi] <= sync1[gi];
        end
      end
      assign act[gi] = pin_en[gi] &&
                       (sync2[gi] == pin_pol[gi]);
    end
  endgenerate

  // software trigger is a level so it also drives external exposure
  assign trig_lvl  = |act || ctrl[`STC_F_SOFT];
  assign trig_edge = trig_lvl && !trig_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_lvl;
    end
  end

  // 15 ns and 1 us enables from the 10 ns clock
  stc_tick_gen #(.NUM(`STC_CLK_NS), .DEN(`STC_TICK_NS)) u_tick15 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick15)
  );
  stc_tick_gen #(.NUM(`STC_CLK_NS), .DEN(`STC_USEC_NS)) u_tick_us (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_us)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      usec <= 32'h0000_0000;
    end else if (tick_us) begin
      usec <= usec + 32'h0000_0001;
    end
  end

  // line geometry: whole granules covering first and last roi pixel
  always_comb begin
    logic [10:0] g;
    logic [10:0] first;
    logic [10:0] last;
    g        = stc_gran(roll);
    first    = col_s - (col_s % g);
    last     = col_e - (col_e % g) + g - 11'h001;
    cols     = last - first + 11'h001;
    line_min = {5'h0, cols} + `STC_LINE_GAP;
    line_eff = (line_per > line_min) ? line_per : line_min;
  end

  assign edge_mode = (mode == STC_MULTI) || (mode == STC_SINGLE);
  assign acc_edge  = trig_edge && edge_mode;
  assign dly_done  = dly_cnt >= delay;
  assign exp_done  = (mode == STC_EXT) ? !trig_lvl
                                       : exp_cnt >= expo;
  assign gap_done  = fp_cnt >= frame_per;
  // >= so a line period shortened mid-line still ends that line
  assign line_end  = lcnt >= line_eff - 16'h0001;
  assign last_row  = row >= rows - 16'h0001;
  assign frame_go  = state != ST_EXPOSE && next_state == ST_EXPOSE;
  // pending trigger restarts a sequence once the current one ends
  assign restart   = state == ST_GAP && gap_done && mode != STC_FREE &&
                     frames_left <= 16'h0001 && pend;
  assign pend_set  = trig_edge && ((mode == STC_EXT) ? state == ST_READ
                     : edge_mode && state != ST_IDLE &&
                       state != ST_DELAY);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (mode == STC_FREE) begin
          next_state = ST_EXPOSE;
        end else if (mode == STC_EXT && trig_edge) begin
          next_state = ST_EXPOSE;
        end else if (acc_edge) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          next_state = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (exp_done) begin
          next_state = ST_LEAD;
        end
      end
      ST_LEAD: next_state = ST_READ;
      ST_READ: begin
        if (line_end && last_row) begin
          if (mode != STC_EXT) begin
            next_state = ST_GAP;
          end else if (pend && trig_lvl) begin
            next_state = ST_EXPOSE;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (gap_done) begin
          if (mode == STC_FREE || frames_left > 16'h0001) begin
            next_state = ST_EXPOSE;
          end else if (pend) begin
            next_state = dly_done ? ST_EXPOSE : ST_DELAY;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // set wins over consumption
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
    end else if (pend_set) begin
      pend <= 1'b1;
    end else if (restart || (state == ST_READ && next_state != ST_READ)
                 && mode == STC_EXT) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frames_left <= 16'h0000;
    end else if ((state == ST_IDLE && acc_edge) || restart) begin
      frames_left <= (mode == STC_SINGLE) ? 16'h0001 : fcount;
    end else if (state == ST_GAP && gap_done && frames_left > 16'h0001) begin
      frames_left <= frames_left - 16'h0001;
    end
  end

  // delay runs from the accepted edge, even during a busy readout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_run <= 1'b0;
      dly_cnt <= 32'h0000_0000;
    end else if ((state == ST_IDLE && acc_edge) ||
                 (pend_set && edge_mode)) begin
      dly_run <= 1'b1;
      dly_cnt <= 32'h0000_0000;
    end else if (frame_go) begin
      dly_run <= 1'b0;
    end else if (dly_run && tick15 && !dly_done) begin
      dly_cnt <= dly_cnt + 32'h0000_0001;
    end
  end

  // frame period and exposure both measured from exposure start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fp_cnt  <= 32'h0000_0000;
      exp_cnt <= 32'h0000_0000;
    end else if (frame_go) begin
      fp_cnt  <= 32'h0000_0000;
      exp_cnt <= 32'h0000_0000;
    end else if (tick15) begin
      fp_cnt  <= fp_cnt + 32'h0000_0001;
      if (state == ST_EXPOSE) begin
        exp_cnt <= exp_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_cap <= 32'h0000_0000;
    end else if (state == ST_EXPOSE && next_state != ST_EXPOSE) begin
      ts_cap <= usec;
    end
  end

  // line and row counters during readout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lcnt <= 16'h0000;
      row  <= 16'h0000;
    end else if (state != ST_READ) begin
      lcnt <= 16'h0000;
      row  <= 16'h0000;
    end else if (line_end) begin
      lcnt <= 16'h0000;
      row  <= row + 16'h0001;
    end else begin
      lcnt <= lcnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fv <= 1'b0;
    end else begin
      fv <= next_state == ST_LEAD || next_state == ST_READ;
    end
  end

  // status word loads as line valid rises on row 0
  assign st.load   = state == ST_READ && row == 16'h0000 &&
                     lcnt == 16'h0000;
  assign st.trig   = trig_seen;
  assign st.fnum   = fnum;
  assign st.tstamp = ts_cap;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_seen <= 1'b0;
      fnum      <= 32'h0000_0000;
    end else begin
      if (trig_edge) begin
        trig_seen <= 1'b1;
      end else if (st.load) begin
        trig_seen <= 1'b0;
      end
      if (st.load) begin
        fnum <= fnum + 32'h0000_0001;
      end
    end
  end

  stc_status_ser u_ser (
    .hclk    (hclk),
    .hresetn (hresetn),
    .st      (st)
  );

  assign line_valid_wire  = state == ST_READ &&
                            lcnt < {5'h0, cols};
  assign frame_valid_wire = st.busy ? st.sbit : fv;
  assign expose_out       = state == ST_EXPOSE;
  assign delay_out        = state == ST_DELAY;

  a_fv_leads_lv: assert property (@(posedge hclk)
    disable iff (!hresetn) $rose(line_valid_wire) |-> $past(fv))
    else $error("frame valid did not lead line valid");
  a_cols_gran: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $rose(line_valid_wire) |-> (cols % stc_gran(roll)) == 11'h000)
    else $error("column count not a whole granule");
  a_line_pad: assert property (@(posedge hclk)
    disable iff (!hresetn) (state == ST_READ && line_end) |->
      lcnt + 16'h0001 >= line_min && lcnt + 16'h0001 >= line_per)
    else $error("line shorter than programmed period");
  a_ts_capture: assert property (@(posedge hclk)
    disable iff (!hresetn) $fell(expose_out) |-> ts_cap == $past(usec))
    else $error("timestamp not taken at end of exposure");
  a_free_ignores: assert property (@(posedge hclk)
    disable iff (!hresetn)
    mode == STC_FREE && $past(mode == STC_FREE) |-> state != ST_DELAY)
    else $error("free running entered trigger delay");
  a_ext_expose: assert property (@(posedge hclk)
    disable iff (!hresetn) (mode == STC_EXT && state == ST_EXPOSE &&
      !trig_lvl) |=> state == ST_LEAD)
    else $error("external exposure outlasted trigger");
  a_gap_period: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (state == ST_GAP && next_state == ST_EXPOSE) |-> fp_cnt >= frame_per)
    else $error("frame started before frame period");
  a_pend_keeps: assert property (@(posedge hclk)
    disable iff (!hresetn) pend_set |=> pend)
    else $error("trigger during busy frame was lost");
endmodule // stc_timing

/* File: testbench/stc_frame_rx.sv */
`timescale 1ns/1ns
// downstream receiver: strips the status word off frame valid
module stc_frame_rx (
  // clock and reset
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // frame wires
  input  wire logic   line_valid_wire,
  input  wire logic   frame_valid_wire,
  // recovered frame
  output logic        fv_clean,
  output logic [64:0] status,
  output int          frames,
  output int          lv_len,
  output int          lv_gap,
  output int          lead
);
  int   nbit;
  int   run;
  int   fv_run;
  logic lv_q;
  logic first;
  // status bits read as frame valid high
  assign fv_clean = (nbit > 0) || frame_valid_wire;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nbit   <= 0;
      run    <= 0;
      fv_run <= 0;
      lv_q   <= 1'b0;
      first  <= 1'b1;
      status <= '0;
      frames <= 0;
      lv_len <= 0;
      lv_gap <= 0;
      lead   <= 0;
    end else begin
      lv_q   <= line_valid_wire;
      run    <= (line_valid_wire != lv_q) ? 1 : run + 1;
      fv_run <= fv_clean ? fv_run + 1 : 0;
      if (!fv_clean) begin
        first <= 1'b1;
      end
      if (line_valid_wire && !lv_q) begin
        if (first) begin
          lead  <= fv_run;
          nbit  <= 65;
          first <= 1'b0;
        end else begin
          lv_gap <= run;
        end
      end
      if (!line_valid_wire && lv_q) begin
        lv_len <= run;
      end
      if (nbit > 0) begin
        status <= {status[63:0], frame_valid_wire};
        nbit   <= nbit - 1;
        frames <= frames + int'(nbit == 1);
      end
    end
  end
endmodule // stc_frame_rx

/* File: testbench/tb_sensor_timing_trigger_control.sv */
`timescale 1ns/1ns
`include "stc_defines.svh"
module tb_sensor_timing_trigger_control;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [1:0]  trig_pin = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, ts;
  logic        hreadyout, hresp, line_valid_wire, frame_valid_wire;
  logic        expose_out, delay_out, fv_clean;
  logic [64:0] status;
  int          frames, lv_len, lv_gap, lead, cyc, n, f0, g;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [7:0]  ra [6] = '{`STC_A_CTRL, `STC_A_ROWS, `STC_A_EXPO,
                          `STC_A_FCNT, `STC_A_COLS, 8'h30};
  logic [31:0] rv [6] = '{32'h0, {16'h0, `STC_RST_ROWS}, `STC_RST_EXPO,
                          {16'h0, `STC_RST_FCNT},
                          {5'h0, `STC_RST_COL_E, 5'h0, `STC_RST_COL_S},
                          32'h0};
  logic [7:0]  cr [3] = '{8'h0, 8'h0, 8'h4};
  logic [10:0] cs [3] = '{11'h3, 11'h3, 11'h5};
  logic [10:0] ce [3] = '{11'hc, 11'hc, 11'h14};
  int          ln [3] = '{30, 4, 40};

  always #5 hclk = ~hclk;

  stc_timing i_dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .trig_pin         (trig_pin),
    .line_valid_wire  (line_valid_wire),
    .frame_valid_wire (frame_valid_wire),
    .expose_out       (expose_out),
    .delay_out        (delay_out)
  );

  stc_frame_rx i_rx (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .line_valid_wire  (line_valid_wire),
    .frame_valid_wire (frame_valid_wire),
    .fv_clean         (fv_clean),
    .status           (status),
    .frames           (frames),
    .lv_len           (lv_len),
    .lv_gap           (lv_gap),
    .lead             (lead)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_idle();
    do ahb(1'b0, `STC_A_STAT, 32'h0); while (rd[5:0] !== 6'h01);
  endtask

  task automatic wait_lvl(input bit ex, input logic v);
    n = 0;
    while ((ex ? expose_out : delay_out) !== v) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // pin level drives the exposure window directly
  task automatic ext_pulse(input logic [1:0] on, off);
    trig_pin <= on;
    wait_lvl(1'b1, 1'b1);
    check("expose start", 32'(n < 6), 32'h1);
    repeat (100) @(posedge hclk);
    trig_pin <= off;
    wait_lvl(1'b1, 1'b0);
    check("expose stop", 32'(n < 6), 32'h1);
  endtask

  // hang guard, generous against roughly 5k cycles of tests
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, 8'h30, 32'h1234_5678);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, ra[i], 32'h0);
      check("reset value", rd, rv[i]);
      check("response", 32'(hresp), 32'h0);
    end
    $display("test registers done");
    ahb(1'b1, `STC_A_ROWS, 32'h4);
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, `STC_A_CTRL, {24'h0, cr[i]});
      ahb(1'b1, `STC_A_COLS, {5'h0, ce[i], 5'h0, cs[i]});
      ahb(1'b1, `STC_A_LINE, 32'(ln[i]));
      g = cr[i][2] ? 16 : 10;
      n = (ce[i] - ce[i] % g + g - 1) - (cs[i] - cs[i] % g) + 1;
      f0 = frames;
      wait (frames >= f0 + 2);
      check("line length", lv_len, n);
      g = (ln[i] > n + 2) ? ln[i] - n : 2;
      check("line gap", lv_gap, g);
      check("lead", lead, 1);
      check("frame number", status[63:32], frames - 1);
      check("flag", 32'(status[64]), 32'h0);
    end
    ts = status[31:0];
    f0 = frames;
    wait (frames > f0);
    ts = status[31:0] - ts;
    check("stamp step", 32'(ts inside {[1:8]}), 32'h1);
    $display("test line timing done");
    ahb(1'b1, `STC_A_CTRL, 32'h22);
    wait_idle();
    ahb(1'b1, `STC_A_DELAY, 32'd20);
    trig_pin <= 2'h1;
    repeat (8) @(posedge hclk);
    ahb(1'b0, `STC_A_STAT, 32'h0);
    check("disabled pin", 32'(rd[5:0]), 32'h1);
    trig_pin <= 2'h0;
    f0 = frames;
    ahb(1'b1, `STC_A_CTRL, 32'h2a);
    trig_pin <= 2'h1;
    wait_lvl(1'b0, 1'b1);
    wait_lvl(1'b0, 1'b0);
    check("delay length", 32'(n inside {[28:33]}), 32'h1);
    trig_pin <= 2'h0;
    repeat (3) @(posedge hclk);
    wait_lvl(1'b1, 1'b1);
    trig_pin <= 2'h1;
    wait (frames > f0);
    check("flag", 32'(status[64]), 32'h1);
    wait_idle();
    check("pending frame", frames, f0 + 2);
    trig_pin <= 2'h0;
    $display("test single done");
    ahb(1'b1, `STC_A_FCNT, 32'h3);
    ahb(1'b1, `STC_A_CTRL, 32'h29);
    f0 = frames;
    trig_pin <= 2'h1;
    wait_lvl(1'b0, 1'b1);
    wait_idle();
    check("burst frames", frames, f0 + 3);
    trig_pin <= 2'h0;
    $display("test multi done");
    ahb(1'b1, `STC_A_CTRL, 32'h2b);
    f0 = frames;
    ext_pulse(2'h1, 2'h0);
    wait_idle();
    check("external frame", frames, f0 + 1);
    trig_pin <= 2'h2;
    ahb(1'b1, `STC_A_CTRL, 32'h13);
    ext_pulse(2'h0, 2'h2);
    wait_idle();
    ahb(1'b1, `STC_A_CTRL, 32'h83);
    wait_lvl(1'b1, 1'b1);
    check("soft expose", 32'(n < 4), 32'h1);
    $display("test external done");
    complete_run();
  end
endmodule // tb_sensor_timing_trigger_control
